/* File: rtl/daoc_fifo.sv */
// sample buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module daoc_fifo #(
    parameter int unsigned W     = 20,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned LW    = 5
) (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    daoc_fifo_if.store bus
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0]   cnt_q;
    logic          out_valid_q;
    logic [W-1:0]  out_data_q;

    wire logic push = bus.in_valid & bus.in_ready;
    wire logic load = (cnt_q != '0) & (~out_valid_q | bus.out_ready);

    // the output register counts toward the depth, so at most DEPTH words are held
    assign bus.in_ready  = ((cnt_q + (AW+1)'(out_valid_q)) != FULL_CNT);
    assign bus.out_valid = out_valid_q;
    assign bus.out_data  = out_data_q;
    assign bus.level     = LW'(cnt_q) + LW'(out_valid_q);

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= bus.in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            cnt_q       <= '0;
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q + AW'(push);
            rd_ptr_q <= rd_ptr_q + AW'(load);
            cnt_q    <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
            if (load)
            begin
                out_valid_q <= 1'b1;
                out_data_q  <= mem_q[rd_ptr_q];
            end
            else if (bus.out_ready)
            begin
                out_valid_q <= 1'b0;
            end
        end
    end
endmodule // daoc_fifo
`default_nettype wire

/* File: rtl/daoc_fifo_if.sv */
// stream carrier between the converter core and its sample buffer
`timescale 1ns/1ps
`default_nettype none
interface daoc_fifo_if #(parameter int unsigned W = 20, parameter int unsigned LW = 5);
    logic          in_valid;
    logic          in_ready;
    logic [W-1:0]  in_data;
    logic          out_valid;
    logic          out_ready;
    logic [W-1:0]  out_data;
    logic [LW-1:0] level;

    modport store (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data, level);
    modport user  (output in_valid, in_data, out_ready,
                   input in_ready, out_valid, out_data, level);
endinterface : daoc_fifo_if
`default_nettype wire

/* File: rtl/daoc_pkg.sv */
// shared constants and types of the dual converter control block
package daoc_pkg;
    localparam int unsigned DATA_W     = 10;
    localparam int unsigned RAW_W      = 12;
    localparam int unsigned WORD_W     = 2 * DATA_W;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned LEVEL_W    = 5;
    localparam int unsigned WAKE_W     = 20;
    localparam int unsigned ADDR_W     = 12;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_LAST   = 12'h008;

    // control register fields
    localparam int unsigned CTRL_FMT_BIT  = 0;
    localparam int unsigned CTRL_GAIN_BIT = 1;
    localparam int unsigned CTRL_STANDBY_REQUEST_BIT = 2;
    localparam int unsigned CTRL_PD_BIT   = 3;
    localparam int unsigned CTRL_OS_BIT   = 4;
    localparam int unsigned CTRL_W        = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h10;

    // status register fields
    localparam int unsigned STAT_MODE_LSB  = 0;
    localparam int unsigned STAT_LEVEL_LSB = 4;
    localparam int unsigned STAT_OVR_LSB   = 16;
    localparam int unsigned OVR_W          = 8;

    // output codes, two's complement view; offset binary flips the top bit
    localparam logic [DATA_W-1:0] CODE_TC_MAX  = 10'h1ff;
    localparam logic [DATA_W-1:0] CODE_TC_MIN  = 10'h200;
    localparam logic [DATA_W-1:0] CODE_OB_MID  = 10'h200;
    localparam logic [DATA_W-1:0] CODE_MSB     = 10'h200;
    localparam logic [DATA_W-1:0] CODE_ZERO    = 10'h000;

    // raw input: signed, half the reference voltage is 2048 counts
    localparam int unsigned GAIN_HI_SHIFT = 2;
    localparam int unsigned GAIN_LO_SHIFT = 1;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_STANDBY_REQUEST,
        MODE_PD,
        MODE_WAKE
    } daoc_mode_t;
endpackage : daoc_pkg

/* File: rtl/daoc_top.sv */
// dual converter output formatting, power modes and output buses
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module daoc_top
    import daoc_pkg::*;
#(
    parameter int unsigned STANDBY_REQUEST_WAKE_CYCLES = 100,
    parameter int unsigned PD_WAKE_CYCLES   = 125000
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     sample_clk,
    input  wire logic signed [RAW_W-1:0]  raw_i,
    input  wire logic signed [RAW_W-1:0]  raw_q,
    output logic      [DATA_W-1:0]        i_bus,
    output logic      [DATA_W-1:0]        q_bus,
    output logic                          bus_valid,
    output logic                          bus_is_q,
    input  wire logic                     bus_ready
);
    localparam logic [WAKE_W-1:0] STANDBY_REQUEST_WAKE = WAKE_W'(STANDBY_REQUEST_WAKE_CYCLES);
    localparam logic [WAKE_W-1:0] PD_WAKE   = WAKE_W'(PD_WAKE_CYCLES);

    daoc_fifo_if #(.W(WORD_W), .LW(LEVEL_W)) fifo_bus ();

    logic [CTRL_W-1:0] ctrl_q;
    logic [WORD_W-1:0] last_q;
    logic [OVR_W-1:0]  ovr_q;
    daoc_mode_t        mode_q;
    daoc_mode_t        mode_d;
    logic [WAKE_W-1:0] wake_q;
    logic [WAKE_W-1:0] wake_d;
    logic              sclk_q;
    logic              phase_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [DATA_W-1:0] i_bus_q;
    logic [DATA_W-1:0] q_bus_q;
    logic              bus_valid_q;
    logic              bus_is_q_q;

    // control decode
    wire logic fmt_tc  = ctrl_q[CTRL_FMT_BIT];
    wire logic gain_hi = ctrl_q[CTRL_GAIN_BIT];
    wire logic standby_request    = ctrl_q[CTRL_STANDBY_REQUEST_BIT];
    wire logic pd      = ctrl_q[CTRL_PD_BIT];
    wire logic os_par  = ctrl_q[CTRL_OS_BIT];

    // apb decode; two-cycle access, pready raised in the second
    wire logic apb_acc  = psel & penable & ~pready_q;
    wire logic apb_done = psel & penable & pready_q;
    wire logic hit_ctrl = (paddr == ADDR_CTRL);
    wire logic hit_stat = (paddr == ADDR_STATUS);
    wire logic hit_last = (paddr == ADDR_LAST);
    wire logic hit_any  = hit_ctrl | hit_stat | hit_last;
    wire logic ctrl_wr  = apb_done & pwrite & hit_ctrl & ~pslverr_q;

    wire logic [31:0] stat_word = (32'(mode_q) << STAT_MODE_LSB)
                                | (32'(fifo_bus.level) << STAT_LEVEL_LSB)
                                | (32'(ovr_q) << STAT_OVR_LSB);
    wire logic [31:0] rd_word   = hit_ctrl ? 32'(ctrl_q)
                                : hit_stat ? stat_word
                                : hit_last ? 32'(last_q)
                                : 32'h0000_0000;

    // sampling strobe: falling edge of the sample clock while running
    wire logic sclk_fall = sclk_q & ~sample_clk;
    wire logic running   = (mode_q == MODE_RUN);
    wire logic convert   = sclk_fall & running;
    wire logic push      = convert & fifo_bus.in_ready;
    wire logic overrun   = convert & ~fifo_bus.in_ready;

    // per-channel scaling, clipping and formatting
    wire logic [DATA_W-1:0] code [2];
    wire logic signed [RAW_W-1:0] raw_ch [2];
    assign raw_ch[0] = raw_i;
    assign raw_ch[1] = raw_q;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            wire logic signed [RAW_W-1:0] hi_s = raw_ch[ch] >>> GAIN_HI_SHIFT;
            wire logic signed [RAW_W-1:0] lo_s = raw_ch[ch] >>> GAIN_LO_SHIFT;
            wire logic signed [RAW_W-1:0] sc   = gain_hi ? hi_s : lo_s;
            wire logic over  = (sc > $signed(RAW_W'(CODE_TC_MAX)));
            wire logic under = (sc < -$signed(RAW_W'(CODE_MSB)));
            // gain low halves the input span, so clip to the 10-bit range
            wire logic [DATA_W-1:0] tc = over  ? CODE_TC_MAX
                                       : under ? CODE_TC_MIN
                                       : sc[DATA_W-1:0];
            assign code[ch] = fmt_tc ? tc : (tc ^ CODE_MSB);
        end
    endgenerate

    assign fifo_bus.in_valid = convert;
    assign fifo_bus.in_data  = {code[0], code[1]};

    // output stage drains only in run mode, so held results stay put
    wire logic out_go   = running & fifo_bus.out_valid & bus_ready;
    wire logic mux_last = ~os_par & phase_q;
    assign fifo_bus.out_ready = out_go & (os_par | phase_q);

    // power mode sequencing; power-down has precedence over standby
    always_comb
    begin
        mode_d = mode_q;
        wake_d = wake_q;
        case (mode_q)
            MODE_RUN, MODE_WAKE:
            begin
                if (pd)
                begin
                    mode_d = MODE_PD;
                end
                else if (standby_request)
                begin
                    mode_d = MODE_STANDBY_REQUEST;
                end
                else if (mode_q == MODE_WAKE)
                begin
                    wake_d = wake_q - WAKE_W'(1);
                    if (wake_q <= WAKE_W'(1))
                    begin
                        mode_d = MODE_RUN;
                    end
                end
            end
            MODE_STANDBY_REQUEST:
            begin
                if (pd)
                begin
                    mode_d = MODE_PD;
                end
                else if (!standby_request)
                begin
                    mode_d = MODE_WAKE;
                    wake_d = STANDBY_REQUEST_WAKE;
                end
            end
            MODE_PD:
            begin
                if (!pd)
                begin
                    mode_d = standby_request ? MODE_STANDBY_REQUEST : MODE_WAKE;
                    wake_d = PD_WAKE;
                end
            end
            default:
            begin
                mode_d = MODE_PD;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= MODE_PD;
            wake_q <= '0;
            sclk_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            wake_q <= wake_d;
            sclk_q <= sample_clk;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q    <= CTRL_RESET;
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= apb_acc;
            pslverr_q <= apb_acc & ~hit_any;
            prdata_q  <= apb_acc & ~pwrite ? rd_word : 32'h0000_0000;
            if (ctrl_wr)
            begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_q <= '0;
            ovr_q  <= '0;
        end
        else
        begin
            if (push)
            begin
                last_q <= fifo_bus.in_data;
            end
            if (overrun && ovr_q != '1)
            begin
                ovr_q <= ovr_q + OVR_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            i_bus_q     <= '0;
            q_bus_q     <= '0;
            bus_valid_q <= 1'b0;
            bus_is_q_q  <= 1'b0;
            phase_q     <= 1'b0;
        end
        else
        begin
            bus_valid_q <= out_go;
            if (!os_par)
            begin
                q_bus_q <= CODE_ZERO;
            end
            if (out_go)
            begin
                bus_is_q_q <= mux_last;
                phase_q    <= ~os_par & ~phase_q;
                if (os_par)
                begin
                    i_bus_q <= fifo_bus.out_data[WORD_W-1:DATA_W];
                    q_bus_q <= fifo_bus.out_data[DATA_W-1:0];
                end
                else
                begin
                    i_bus_q <= phase_q ? fifo_bus.out_data[DATA_W-1:0]
                                       : fifo_bus.out_data[WORD_W-1:DATA_W];
                end
            end
        end
    end

    daoc_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH), .LW(LEVEL_W)) u_fifo (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (fifo_bus)
    );

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign i_bus     = i_bus_q;
    assign q_bus     = q_bus_q;
    assign bus_valid = bus_valid_q;
    assign bus_is_q  = bus_is_q_q;

    sequence s_leave_standby_request;
        mode_q == MODE_STANDBY_REQUEST && !standby_request && !pd;
    endsequence
    sequence s_leave_pd;
        mode_q == MODE_PD && !pd && !standby_request;
    endsequence

    a_ob_midscale: assert property (@(posedge mclk) disable iff (!rst_n)
        push && !fmt_tc && raw_i == '0 |-> fifo_bus.in_data[WORD_W-1:DATA_W] == CODE_OB_MID)
        else $error("offset binary midscale wrong");
    a_tc_fullscale: assert property (@(posedge mclk) disable iff (!rst_n)
        push && fmt_tc && raw_q == $signed(12'h7ff) |-> fifo_bus.in_data[DATA_W-1:0] == CODE_TC_MAX)
        else $error("two's complement full scale wrong");
    a_gain_low_clip: assert property (@(posedge mclk) disable iff (!rst_n)
        push && !gain_hi && fmt_tc && raw_i == $signed(12'h800)
        |-> fifo_bus.in_data[WORD_W-1:DATA_W] == CODE_TC_MIN)
        else $error("low gain negative clip wrong");
    a_no_conv_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        !running |-> !fifo_bus.in_valid ##1 !bus_valid)
        else $error("activity outside run mode");
    a_hold_bus: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode_q == MODE_STANDBY_REQUEST || mode_q == MODE_PD) && $past(mode_q) != MODE_RUN
        |=> $stable(i_bus) && (!os_par || $stable(q_bus)))
        else $error("buses changed in low power");
    a_pd_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        pd && standby_request |=> mode_q == MODE_PD)
        else $error("power-down did not take precedence");
    a_wake_standby_request: assert property (@(posedge mclk) disable iff (!rst_n)
        s_leave_standby_request |=> mode_q == MODE_WAKE && wake_q == STANDBY_REQUEST_WAKE)
        else $error("standby recovery count wrong");
    a_wake_pd: assert property (@(posedge mclk) disable iff (!rst_n)
        s_leave_pd |=> mode_q == MODE_WAKE && wake_q == PD_WAKE && wake_q > STANDBY_REQUEST_WAKE)
        else $error("power-down recovery count wrong");
    a_mux_q_low: assert property (@(posedge mclk) disable iff (!rst_n)
        !os_par |=> q_bus == CODE_ZERO)
        else $error("q bus not low in multiplexed mode");
    a_fall_sample: assert property (@(posedge mclk) disable iff (!rst_n)
        fifo_bus.in_valid |-> $past(sample_clk) && !sample_clk)
        else $error("sample not on falling edge");
endmodule // daoc_top
`default_nettype wire

/* File: tb/daoc_sink.sv */
// downstream capture model for the converted sample buses
`timescale 1ns/1ps
`default_nettype none
module daoc_sink
    import daoc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [DATA_W-1:0] i_bus,
    input  wire logic [DATA_W-1:0] q_bus,
    input  wire logic              bus_valid,
    input  wire logic              bus_is_q,
    input  wire logic              stall,
    input  wire logic              slow,
    output logic                   bus_ready
);
    logic [2*DATA_W:0] cap_q[$];
    logic [1:0]        cnt_q;

    // slow mode accepts only half the time, so the buffer backs up
    assign bus_ready = !stall && (!slow || cnt_q[1]);

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 2'h0;
        else
        begin
            cnt_q <= cnt_q + 2'h1;
            if (bus_valid === 1'b1)
                cap_q.push_back({bus_is_q, i_bus, q_bus});
        end
    end
endmodule // daoc_sink
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the dual converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import daoc_pkg::*;
;
    localparam int SW = 4;
    localparam int PW = 16;

    logic                     mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0]        paddr;
    logic [31:0]              pwdata, prdata;
    logic                     sample_clk, stall, slow, bus_valid, bus_is_q, bus_ready;
    logic signed [RAW_W-1:0]  raw_i, raw_q;
    logic [DATA_W-1:0]        i_bus, q_bus;
    int                       fails, cmp_count, seed, cyc;
    bit                       fmt, gain, os, run;
    logic [21:0]              exp_q[$];
    logic [19:0]              last;

    always #4 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    daoc_top #(.STANDBY_REQUEST_WAKE_CYCLES(SW), .PD_WAKE_CYCLES(PW)) dut (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_clk(sample_clk), .raw_i(raw_i), .raw_q(raw_q),
        .i_bus(i_bus), .q_bus(q_bus), .bus_valid(bus_valid), .bus_is_q(bus_is_q),
        .bus_ready(bus_ready));

    daoc_sink sink (
        .mclk(mclk), .rst_n(rst_n), .i_bus(i_bus), .q_bus(q_bus), .bus_valid(bus_valid),
        .bus_is_q(bus_is_q), .stall(stall), .slow(slow), .bus_ready(bus_ready));

    task summarize;
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk_field(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task chk_sample(input logic [20:0] got, input logic [21:0] e);
        logic [20:0] m;
        // the bus tag only means something in multiplexed mode
        m = e[21] ? 21'h1fffff : 21'h0fffff;
        cmp_count++;
        if ((got & m) !== (e[20:0] & m))
        begin
            fails++;
            $display("MISMATCH %0t sample got %h exp %h", $time, got, e[20:0]);
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 64)
            chk_field(32'h0, 32'h1, "apb timeout");
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    task automatic set_ctrl(input bit standby_request, input bit pd);
        logic [31:0] r;
        logic e;
        apb(1'b1, ADDR_CTRL, {27'h0, os, pd, standby_request, gain, fmt}, r, e);
    endtask

    task automatic wait_mode(input logic [1:0] m, output int n);
        int t0;
        logic [31:0] r;
        t0 = cyc;
        for (int k = 0; k < 100; k++)
        begin
            rd(ADDR_STATUS, r);
            if (r[1:0] === m)
                break;
        end
        n = cyc - t0;
        chk_field({30'h0, r[1:0]}, {30'h0, m}, "mode");
    endtask

    function automatic logic [9:0] code(input int raw, input bit g, input bit f);
        int v;
        v = g ? (raw >>> 2) : (raw >>> 1);
        if (v > 511)
            v = 511;
        if (v < -512)
            v = -512;
        code = f ? v[9:0] : (v[9:0] ^ CODE_MSB);
    endfunction

    function automatic int rnd();
        rnd = $random(seed) % 2048;
    endfunction

    task automatic conv(input int i, input int q);
        logic [9:0] ci, cq;
        @(posedge mclk);
        raw_i <= i[11:0];
        raw_q <= q[11:0];
        sample_clk <= 1'b1;
        repeat (2) @(posedge mclk);
        sample_clk <= 1'b0;
        @(posedge mclk);
        ci = code(i, gain, fmt);
        cq = code(q, gain, fmt);
        if (run)
        begin
            last = {ci, cq};
            if (os)
                exp_q.push_back({2'b00, ci, cq});
            else
            begin
                exp_q.push_back({2'b10, ci, 10'h000});
                exp_q.push_back({2'b11, cq, 10'h000});
            end
        end
    endtask

    task automatic drain(input int keep);
        for (int k = 0; k < 800 && sink.cap_q.size() < keep; k++)
            @(posedge mclk);
        repeat (8) @(posedge mclk);
        chk_field(sink.cap_q.size(), keep, "count");
        for (int k = 0; k < keep && sink.cap_q.size() > 0; k++)
            chk_sample(sink.cap_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
        sink.cap_q.delete();
    endtask

    task automatic hold_chk();
        for (int k = 0; k < 3; k++)
            conv(rnd(), rnd());
        repeat (12) @(posedge mclk);
        chk_field(sink.cap_q.size(), 0, "held count");
        chk_field({12'h0, i_bus, q_bus}, {12'h0, last}, "held bus");
    endtask

    initial
    begin
        #150000;
        fails++;
        summarize();
    end

    initial
    begin
        int n, ns, np;
        logic [31:0] r;
        logic e;
        mclk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, sample_clk, stall, slow} = 6'h0;
        paddr = '0;
        pwdata = 32'h0;
        raw_i = '0;
        raw_q = '0;
        {fails, cmp_count} = {32'h0, 32'h0};
        seed = 32'he616;
        {fmt, gain, os, run} = 4'b0010;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, r);
        chk_field(r, {27'h0, CTRL_RESET}, "ctrl reset");
        apb(1'b1, 12'h00c, 32'h1f, r, e);
        chk_field({31'h0, e}, 32'h1, "unmapped write");
        apb(1'b0, 12'h00c, 32'h0, r, e);
        chk_field({r[31:1], e}, 32'h1, "unmapped read");
        rd(ADDR_CTRL, r);
        chk_field(r, 32'h10, "ctrl kept");
        wait_mode(2'd0, n);
        run = 1'b1;
        for (int g = 0; g < 2; g++)
            for (int f = 0; f < 2; f++)
            begin
                gain = g[0];
                fmt = f[0];
                set_ctrl(1'b0, 1'b0);
                conv(2047, -2048);
                conv(0, 0);
                conv(-2048, 2047);
                conv(1023, -1024);
                conv(rnd(), rnd());
                drain(exp_q.size());
                rd(ADDR_LAST, r);
                chk_field(r, {12'h0, last}, "last");
            end
        os = 1'b0;
        slow <= 1'b1;
        set_ctrl(1'b0, 1'b0);
        for (int k = 0; k < 4; k++)
            conv(rnd(), rnd());
        drain(exp_q.size());
        chk_field({22'h0, q_bus}, 32'h0, "q idle");
        os = 1'b1;
        slow <= 1'b0;
        set_ctrl(1'b0, 1'b0);
        conv(rnd(), rnd());
        drain(exp_q.size());
        set_ctrl(1'b1, 1'b0);
        wait_mode(2'd1, n);
        run = 1'b0;
        hold_chk();
        set_ctrl(1'b0, 1'b0);
        wait_mode(2'd0, ns);
        run = 1'b1;
        conv(rnd(), rnd());
        drain(exp_q.size());
        set_ctrl(1'b1, 1'b1);
        wait_mode(2'd2, n);
        run = 1'b0;
        hold_chk();
        set_ctrl(1'b0, 1'b0);
        wait_mode(2'd3, n);
        wait_mode(2'd0, np);
        np = np + n;
        run = 1'b1;
        chk_field({31'h0, ns < np}, 32'h1, "wake order");
        chk_field({31'h0, np >= PW && ns >= SW}, 32'h1, "wake length");
        // stalled sink: the buffer must refuse once full and count drops
        stall <= 1'b1;
        for (int k = 0; k < 20; k++)
            conv(rnd(), rnd());
        rd(ADDR_STATUS, r);
        chk_field({27'h0, r[8:4]}, 32'h10, "level full");
        n = r[23:16];
        chk_field({31'h0, n > 0 && n <= 4}, 32'h1, "overrun");
        stall <= 1'b0;
        drain(20 - n);
        rd(ADDR_STATUS, r);
        chk_field({27'h0, r[8:4]}, 32'h0, "level empty");
        summarize();
    end
endmodule // tb_top
`default_nettype wire
